// ---- pds_pkg.sv ----
/*
 Shared constants and types of the program/data space access unit:
 register offsets, field positions, reset values, fixed data-space map,
 request and response carriers and the controller state encoding.
 Assumes one 100 MHz clock and an APB master with 32-bit data.
*/
package pds_pkg;

    ////////////////////////////////////////////////////////////////////////
    // apb register map (byte addresses)
    localparam logic [11:0] OFS_CORE_CTRL = 12'h000;
    localparam logic [11:0] OFS_WIN_PAGE = 12'h004;
    localparam logic [11:0] OFS_TBL_PAGE = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00C;
    localparam logic [11:0] OFS_MOD_START = 12'h010;
    localparam logic [11:0] OFS_MOD_END = 12'h014;

    // core control fields
    localparam int CTRL_WIN_EN_BIT = 0;
    localparam int CTRL_MOD_X_BIT = 1;
    localparam int CTRL_MOD_Y_BIT = 2;
    localparam int CTRL_W = 3;

    // reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [7:0] WIN_PAGE_RST = 8'h00;
    localparam logic [7:0] TBL_PAGE_RST = 8'h00;
    localparam logic [15:0] MOD_START_RST = 16'h0000;
    localparam logic [15:0] MOD_END_RST = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // fixed data-space map; the x/y boundary is wired, not programmable
    localparam logic [15:0] Y_BASE = 16'h1800;
    localparam logic [15:0] Y_END = 16'h27FF;
    localparam logic [15:0] IMPL_END = 16'h27FF;
    localparam int EA_MSB = 15;
    localparam int WIN_LOW_BITS = 15;
    // bit-reversed span: address bits [BR_BITS:1] are reversed
    localparam int BR_BITS = 4;
    // program word stride in address units
    localparam logic [23:0] PC_STEP = 24'h000002;

    // window penalties in cycles
    localparam logic [1:0] PEN_NONE = 2'h0;
    localparam logic [1:0] PEN_ONE = 2'h1;
    localparam logic [1:0] PEN_TWO = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_WRITE = 3'h1,
        OP_TBL_RD_LO = 3'h2,
        OP_TBL_RD_HI = 3'h3,
        OP_DUAL = 3'h4
    } pds_op_e;

    typedef enum logic [1:0] {
        CLS_MAC_PREFETCH = 2'h0,
        CLS_MOVE = 2'h1,
        CLS_DOUBLE_MOVE = 2'h2,
        CLS_OTHER = 2'h3
    } pds_cls_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_CAPTURE = 4'b0100,
        ST_STALL = 4'b1000
    } pds_state_e;

    typedef struct packed {
        pds_op_e op;
        logic is_byte;
        pds_cls_e cls;
        logic in_repeat;
        logic repeat_edge;
        logic bit_rev;
        logic [15:0] ea_x;
        logic [15:0] ea_y;
        logic [15:0] wdata;
    } pds_req_s;

    typedef struct packed {
        logic [15:0] x_data;
        logic [15:0] y_data;
    } pds_rsp_s;

    typedef struct packed {
        pds_state_e state;
        pds_req_s req;
        logic [1:0] pen;
        logic [1:0] last_pen;
        logic redirect;
        logic x_inv;
        logic y_inv;
        logic busy;
        logic pm_rd;
        logic [23:0] pm_addr;
        logic xr_rd;
        logic [15:0] xr_addr;
        logic yr_rd;
        logic [15:0] yr_addr;
        logic xw_wr;
        logic [15:0] xw_addr;
        logic [15:0] xw_data;
        logic [1:0] xw_be;
        logic rsp_valid;
        pds_rsp_s rsp;
        logic [2:0] ctrl;
        logic [7:0] win_page;
        logic [7:0] tbl_page;
        logic [15:0] mod_start;
        logic [15:0] mod_end;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } pds_st_s;

endpackage

// ---- pds_access.sv ----
/*
 Program/data space access unit: table reads of 24-bit program words,
 the data-space window onto a program page, x/y routing for dual fetches,
 and its APB register file.
 Assumes program memory, x memory and y memory answer a read strobe with
 data in the following cycle, and that the core waits for the answer.
*/
// Implementation choices: the APB interface to the registers and the placing of the registers.
// Functional notes
// - 24-bit program words, address steps by two
// - word low table read returns bits 15:0
// - byte low table read picks byte by select
// - word high table read, upper byte zero
// - byte high read, select one gives zero
// - redirect only if ea msb and enabled
// - window address from page and ea 14:0
// - window reads return low 16 bits
// - no window redirect during table accesses
// - outside repeat, window adds one or two
// - inside repeat, edges add two, else none
// - all writes go over x write bus
// - bit reverse on x writes, modulo both
// - dual fetch: y pointers y only, x x
// - invalid or cross-space reads return zero
// - 16-bit byte ea, upper half is x
// - x/y boundary fixed in hardware
// - 16-bit data path, byte-addressable words
// - table page bit 7 selects configuration
module pds_access
    import pds_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic REQ_VALID,
    input wire pds_pkg::pds_req_s REQ,
    output logic BUSY,
    output logic RSP_VALID,
    output pds_pkg::pds_rsp_s RSP,
    output logic PM_RD,
    output logic [23:0] PM_ADDR,
    input wire logic [23:0] PM_RDATA,
    output logic XR_RD,
    output logic [15:0] XR_ADDR,
    input wire logic [15:0] XR_RDATA,
    output logic YR_RD,
    output logic [15:0] YR_ADDR,
    input wire logic [15:0] YR_RDATA,
    output logic XW_WR,
    output logic [15:0] XW_ADDR,
    output logic [15:0] XW_DATA,
    output logic [1:0] XW_BE
);
    import pds_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // address helpers

    // boundary comes from fixed constants only
    function automatic logic in_y(input logic [15:0] a);
        in_y = (a >= Y_BASE) && (a <= Y_END);
    endfunction

    function automatic logic implemented(input logic [15:0] a);
        implemented = (a <= IMPL_END);
    endfunction

    // circular buffer wrap between start and end (word steps)
    function automatic logic [15:0] wrap(input logic [15:0] a, input logic en,
                                         input logic [15:0] s, input logic [15:0] e);
        logic [15:0] len;
        len = 16'(e - s + 16'h0002);
        if (en && (a > e))
            wrap = 16'(a - len);
        else if (en && (a < s))
            wrap = 16'(a + len);
        else
            wrap = a;
    endfunction

    function automatic logic [15:0] bit_reverse(input logic [15:0] a);
        logic [15:0] b;
        b = a;
        for (int i = 1; i <= BR_BITS; i++)
            b[i] = a[BR_BITS + 1 - i];
        bit_reverse = b;
    endfunction

    function automatic logic [1:0] penalty(input pds_req_s q);
        if (q.in_repeat)
            penalty = q.repeat_edge ? PEN_TWO : PEN_NONE;
        else if (q.cls == CLS_OTHER)
            penalty = PEN_TWO;
        else
            penalty = PEN_ONE;
    endfunction

    // byte lane taken from ea bit 0
    function automatic logic [15:0] pick_byte(input logic [15:0] w, input logic sel);
        pick_byte = {8'h00, sel ? w[15:8] : w[7:0]};
    endfunction

    function automatic logic [15:0] table_format(input pds_req_s q, input logic [23:0] p);
        logic [15:0] d;
        d = 16'h0000;
        if (q.op == OP_TBL_RD_LO)
        begin
            // low word or one of its bytes
            d = q.is_byte ? pick_byte(p[15:0], q.ea_x[0]) : p[15:0];
        end
        else
        begin
            // high byte, phantom byte reads zero
            d = (q.is_byte && q.ea_x[0]) ? 16'h0000 : {8'h00, p[23:16]};
        end
        table_format = d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    pds_st_s r;
    pds_st_s n;
    pds_req_s q;
    logic win_hit;
    logic [15:0] word_x;
    logic apb_setup;
    logic apb_write;

    always_comb
    begin
        n = r;
        n.pm_rd = 1'b0;
        n.xr_rd = 1'b0;
        n.yr_rd = 1'b0;
        n.xw_wr = 1'b0;
        n.rsp_valid = 1'b0;

        q = REQ;
        q.ea_x = wrap(REQ.ea_x, r.ctrl[CTRL_MOD_X_BIT], r.mod_start, r.mod_end);
        q.ea_y = wrap(REQ.ea_y, r.ctrl[CTRL_MOD_Y_BIT], r.mod_start, r.mod_end);
        // redirect needs ea msb and the enable bit
        win_hit = q.ea_x[EA_MSB] && r.ctrl[CTRL_WIN_EN_BIT];
        word_x = 16'h0000;

        case (r.state)
            ST_IDLE:
            begin
                if (REQ_VALID)
                begin
                    n.req = q;
                    n.busy = 1'b1;
                    n.state = ST_WAIT;
                    n.redirect = 1'b0;
                    n.x_inv = 1'b0;
                    n.y_inv = 1'b1;
                    n.pen = PEN_NONE;
                    case (q.op)
                        OP_TBL_RD_LO, OP_TBL_RD_HI:
                        begin
                            // table page supplies bits 23:16, window ignored
                            n.pm_rd = 1'b1;
                            n.pm_addr = {r.tbl_page, q.ea_x};
                        end
                        OP_WRITE:
                        begin
                            // single write path, bit reverse on x writes
                            n.xw_wr = 1'b1;
                            n.xw_addr = q.bit_rev ? bit_reverse(q.ea_x) : q.ea_x;
                            n.xw_data = q.is_byte ? {2{q.wdata[7:0]}} : q.wdata;
                            n.xw_be = q.is_byte ? (q.ea_x[0] ? 2'b10 : 2'b01) : 2'b11;
                        end
                        default:
                        begin
                            if (win_hit)
                            begin
                                // page over ea 14:0, bit 23 clear
                                n.pm_rd = 1'b1;
                                n.pm_addr = {1'b0, r.win_page, q.ea_x[WIN_LOW_BITS - 1:0]};
                                n.redirect = 1'b1;
                                n.pen = penalty(q);
                            end
                            // upper half is x, x pointers avoid y
                            else if (implemented(q.ea_x) && !(q.op == OP_DUAL && in_y(q.ea_x)))
                            begin
                                n.xr_rd = 1'b1;
                                n.xr_addr = q.ea_x;
                            end
                            else
                            begin
                                n.x_inv = 1'b1;
                            end
                            // y pointers address y space only, read only
                            if (q.op == OP_DUAL && in_y(q.ea_y))
                            begin
                                n.yr_rd = 1'b1;
                                n.yr_addr = q.ea_y;
                                n.y_inv = 1'b0;
                            end
                        end
                    endcase
                end
            end
            ST_WAIT:
            begin
                n.state = ST_CAPTURE;
            end
            ST_CAPTURE:
            begin
                if (r.req.op == OP_TBL_RD_LO || r.req.op == OP_TBL_RD_HI)
                    word_x = table_format(r.req, PM_RDATA);
                // window keeps the low 16 bits only
                else if (r.redirect)
                    word_x = PM_RDATA[15:0];
                else
                    word_x = XR_RDATA;
                // byte reads use one word lane
                if (r.req.op == OP_READ && r.req.is_byte)
                    word_x = pick_byte(word_x, r.req.ea_x[0]);
                n.rsp.x_data = (r.x_inv || r.req.op == OP_WRITE) ? 16'h0000 : word_x;
                n.rsp.y_data = r.y_inv ? 16'h0000 : YR_RDATA;
                n.last_pen = r.pen;
                if (r.pen == PEN_NONE)
                begin
                    n.state = ST_IDLE;
                    n.busy = 1'b0;
                    n.rsp_valid = 1'b1;
                end
                else
                begin
                    n.state = ST_STALL;
                end
            end
            ST_STALL:
            begin
                // extra cycles for the second program fetch
                n.pen = 2'(r.pen - PEN_ONE);
                if (r.pen == PEN_ONE)
                begin
                    n.state = ST_IDLE;
                    n.busy = 1'b0;
                    n.rsp_valid = 1'b1;
                end
            end
            default:
            begin
                n.state = ST_IDLE;
                n.busy = 1'b0;
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        // apb slave: no wait states, ready in the first access cycle
        apb_setup = PSEL && !PENABLE;
        apb_write = PSEL && PENABLE && r.pready && PWRITE;
        n.pready = apb_setup;
        if (apb_setup)
        begin
            n.pslverr = 1'b0;
            n.prdata = 32'h00000000;
            case (PADDR)
                OFS_CORE_CTRL: n.prdata = {29'h0, r.ctrl};
                OFS_WIN_PAGE: n.prdata = {24'h0, r.win_page};
                OFS_TBL_PAGE: n.prdata = {24'h0, r.tbl_page};
                OFS_STATUS: n.prdata = {26'h0, r.last_pen, r.y_inv, r.x_inv, r.redirect, r.busy};
                OFS_MOD_START: n.prdata = {16'h0, r.mod_start};
                OFS_MOD_END: n.prdata = {16'h0, r.mod_end};
                default: n.pslverr = 1'b1;
            endcase
            if (PWRITE)
                n.prdata = 32'h00000000;
        end
        if (apb_write)
        begin
            case (PADDR)
                OFS_CORE_CTRL: n.ctrl = PWDATA[CTRL_W - 1:0];
                OFS_WIN_PAGE: n.win_page = PWDATA[7:0];
                OFS_TBL_PAGE: n.tbl_page = PWDATA[7:0];
                OFS_MOD_START: n.mod_start = {PWDATA[15:1], 1'b0};
                OFS_MOD_END: n.mod_end = {PWDATA[15:1], 1'b0};
                default: n.ctrl = r.ctrl;
            endcase
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            r <= '0;
            r.state <= ST_IDLE;
            r.ctrl <= CTRL_RST;
            r.win_page <= WIN_PAGE_RST;
            r.tbl_page <= TBL_PAGE_RST;
            r.mod_start <= MOD_START_RST;
            r.mod_end <= MOD_END_RST;
        end
        else
        begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign PRDATA = r.prdata;
    assign PREADY = r.pready;
    assign PSLVERR = r.pslverr;
    assign BUSY = r.busy;
    assign RSP_VALID = r.rsp_valid;
    assign RSP = r.rsp;
    assign PM_RD = r.pm_rd;
    assign PM_ADDR = r.pm_addr;
    assign XR_RD = r.xr_rd;
    assign XR_ADDR = r.xr_addr;
    assign YR_RD = r.yr_rd;
    assign YR_ADDR = r.yr_addr;
    assign XW_WR = r.xw_wr;
    assign XW_ADDR = r.xw_addr;
    assign XW_DATA = r.xw_data;
    assign XW_BE = r.xw_be;

endmodule // pds_access

// ---- pds_mem_model.sv ----
/*
 Program, x and y read memories beside the access unit.
 Assumes each read strobe is answered in the following cycle.
*/
module pds_mem_model (
    input wire logic REF_CLK,
    input wire logic PM_RD,
    input wire logic [23:0] PM_ADDR,
    output logic [23:0] PM_RDATA,
    input wire logic XR_RD,
    input wire logic [15:0] XR_ADDR,
    output logic [15:0] XR_RDATA,
    input wire logic YR_RD,
    input wire logic [15:0] YR_ADDR,
    output logic [15:0] YR_RDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] PM_TOP = 8'hFF;
    initial {PM_RDATA, XR_RDATA, YR_RDATA} = 56'h0;
    // valid one cycle after the strobe, toggling otherwise
    always @(posedge REF_CLK)
    begin
        PM_RDATA <= PM_RD ? {PM_TOP, PM_ADDR[15:0] ^ {PM_ADDR[23:16], 8'h00}} : ~PM_RDATA;
        XR_RDATA <= XR_RD ? XR_ADDR ^ 16'h5A5A : ~XR_RDATA;
        YR_RDATA <= YR_RD ? YR_ADDR ^ 16'hC3C3 : ~YR_RDATA;
    end
endmodule // pds_mem_model

// ---- pds_access_properties.sv ----
/*
 Port checker of the access unit, bound to it.
 Assumes one clock and a synchronous active-high reset.
*/
module pds_access_props
    import pds_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic REQ_VALID,
    input wire pds_pkg::pds_req_s REQ,
    input wire logic BUSY,
    input wire logic RSP_VALID,
    input wire pds_pkg::pds_rsp_s RSP,
    input wire logic PM_RD,
    input wire logic [23:0] PM_ADDR,
    input wire logic XR_RD,
    input wire logic YR_RD,
    input wire logic [15:0] YR_ADDR,
    input wire logic XW_WR
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ea_q;
    logic take;
    logic rd;
    logic tbl;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    assign take = REQ_VALID && !BUSY;
    assign rd = take && REQ.op == OP_READ;
    assign tbl = take && (REQ.op == OP_TBL_RD_LO || REQ.op == OP_TBL_RD_HI);
    always_ff @(posedge REF_CLK)
    begin
        ea_q <= REQ.ea_x;
    end
    ////////////////////////////////////////
    win_gate_a: assert property (rd && !REQ.ea_x[15] |=> !PM_RD)
        else $error("program read outside window");
    tbl_direct_a: assert property (tbl |=> PM_RD && PM_ADDR[15:0] == ea_q)
        else $error("table address wrong");
    win_addr_a: assert property (rd && REQ.ea_x[15] ##1 PM_RD |->
        !PM_ADDR[23] && PM_ADDR[14:0] == ea_q[14:0])
        else $error("window address wrong");
    y_range_a: assert property (YR_RD |-> YR_ADDR >= Y_BASE && YR_ADDR <= Y_END)
        else $error("y read outside y space");
    bad_ea_a: assert property (rd && !REQ.ea_x[15] && REQ.ea_x > IMPL_END |=>
        !XR_RD && !PM_RD ##2 RSP_VALID && RSP.x_data == 16'h0000)
        else $error("unimplemented read wrong");
    wr_xbus_a: assert property (take && REQ.op == OP_WRITE |=> XW_WR && !YR_RD ##2 RSP_VALID)
        else $error("write not on x bus");
    rep_mid_a: assert property (rd && REQ.in_repeat && !REQ.repeat_edge |=>
        !RSP_VALID [*2] ##1 RSP_VALID)
        else $error("repeat read not single cycle");
    other_pen_a: assert property (rd && !REQ.in_repeat && REQ.cls == CLS_OTHER ##1 PM_RD |=>
        !RSP_VALID [*3] ##1 RSP_VALID)
        else $error("window penalty wrong");
    x_no_y_a: assert property (take && REQ.op == OP_DUAL && REQ.ea_x >= Y_BASE &&
        REQ.ea_x <= Y_END |=> !XR_RD)
        else $error("x pointer read y space");
    cover property (rd ##1 PM_RD);
    cover property (take && REQ.op == OP_DUAL ##1 YR_RD);
    cover property (take && REQ.op == OP_WRITE ##1 XW_WR);
endmodule // pds_access_props

bind pds_access pds_access_props i_pds_access_props (.REF_CLK(REF_CLK), .SRST(SRST),
    .REQ_VALID(REQ_VALID), .REQ(REQ), .BUSY(BUSY), .RSP_VALID(RSP_VALID), .RSP(RSP),
    .PM_RD(PM_RD), .PM_ADDR(PM_ADDR), .XR_RD(XR_RD), .YR_RD(YR_RD), .YR_ADDR(YR_ADDR),
    .XW_WR(XW_WR));

// ---- tb.sv ----
/*
 Self-checking bench of the access unit with its memory model.
 Assumes the memories answer one cycle after each strobe.
*/
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pds_pkg::*;
    localparam logic [15:0] X_KEY = 16'h5A5A;
    localparam logic [15:0] Y_KEY = 16'hC3C3;
    localparam logic [15:0] W_DATA = 16'hB7E1;
    localparam logic [15:0] NIL = 16'h0000;
    localparam logic [15:0] TE = 16'hC7A6;
    localparam logic [15:0] TO = 16'hC7A7;
    localparam logic [15:0] XA = 16'h0800;
    localparam logic [15:0] YA = 16'h1800;
    localparam logic [7:0] TP = 8'h81;
    localparam logic [7:0] WP = 8'h12;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic req_valid = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    pds_req_s req = 57'h0;
    pds_rsp_s rsp;
    logic pready, pslverr, busy, rsp_valid, pm_rd, xr_rd, yr_rd, xw_wr, err;
    logic [31:0] prdata, rdat;
    logic [23:0] pm_addr, pm_rdata, pa;
    logic [15:0] xr_addr, xr_rdata, yr_addr, yr_rdata, xw_addr, xw_data, wa, wd, lo0, lo1;
    logic [1:0] xw_be, wb;
    int bad_count = 0;
    int n_compared = 0;

    pds_access i_pds_access (
        .REF_CLK(ref_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .REQ_VALID(req_valid), .REQ(req), .BUSY(busy), .RSP_VALID(rsp_valid), .RSP(rsp),
        .PM_RD(pm_rd), .PM_ADDR(pm_addr), .PM_RDATA(pm_rdata), .XR_RD(xr_rd),
        .XR_ADDR(xr_addr), .XR_RDATA(xr_rdata), .YR_RD(yr_rd), .YR_ADDR(yr_addr),
        .YR_RDATA(yr_rdata), .XW_WR(xw_wr), .XW_ADDR(xw_addr), .XW_DATA(xw_data), .XW_BE(xw_be));
    pds_mem_model i_pds_mem_model (
        .REF_CLK(ref_clk), .PM_RD(pm_rd), .PM_ADDR(pm_addr), .PM_RDATA(pm_rdata),
        .XR_RD(xr_rd), .XR_ADDR(xr_addr), .XR_RDATA(xr_rdata), .YR_RD(yr_rd),
        .YR_ADDR(yr_addr), .YR_RDATA(yr_rdata));

    ////////////////////////////////////////
    initial forever #5 ref_clk = ~ref_clk;
    // keep the last x write
    always @(posedge ref_clk)
    begin
        if (xw_wr === 1'b1)
            {wa, wd, wb} <= {xw_addr, xw_data, xw_be};
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // pready ends this wait, or else the watchdog
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // f = {byte, in repeat, repeat edge, bit reverse}; en = cycles to answer
    task automatic go(input pds_op_e op, input logic [3:0] f, input pds_cls_e c,
        input logic [15:0] x, input logic [15:0] y, input logic [15:0] ex,
        input logic [15:0] ey, input int en);
        int n;
        @(posedge ref_clk);
        req <= {op, f[3], c, f[2:0], x, y, W_DATA};
        req_valid <= 1'b1;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        @(posedge ref_clk);
        chk(busy, 1'b1);
        n = 1;
        while (rsp_valid !== 1'b1 && n < 20)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk(rsp.x_data, ex);
        chk(rsp.y_data, ey);
        chk(n, en);
    endtask

    ////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, OFS_CORE_CTRL, 32'h0);
        chk(rdat, {29'h0, CTRL_RST});
        apb(1'b1, OFS_TBL_PAGE, {24'h0, TP});
        apb(1'b0, OFS_TBL_PAGE, 32'h0);
        chk(rdat, {24'h0, TP});
        apb(1'b1, 12'h020, 32'hFFFFFFFF);
        chk(err, 1'b1);
        apb(1'b1, OFS_CORE_CTRL, 32'h1);
        $display("registers done");
    endtask

    task automatic t_table;
        lo0 = TE ^ {TP, 8'h00};
        lo1 = TO ^ {TP, 8'h00};
        go(OP_TBL_RD_LO, 4'h0, CLS_MOVE, TE, NIL, lo0, NIL, 3);
        go(OP_TBL_RD_LO, 4'h8, CLS_MOVE, TE, NIL, {8'h00, lo0[7:0]}, NIL, 3);
        go(OP_TBL_RD_LO, 4'h8, CLS_MOVE, TO, NIL, {8'h00, lo1[15:8]}, NIL, 3);
        go(OP_TBL_RD_HI, 4'h0, CLS_MOVE, TE, NIL, 16'h00FF, NIL, 3);
        go(OP_TBL_RD_HI, 4'h8, CLS_MOVE, TE, NIL, 16'h00FF, NIL, 3);
        go(OP_TBL_RD_HI, 4'h8, CLS_MOVE, TO, NIL, NIL, NIL, 3);
        $display("table done");
    endtask

    task automatic t_window;
        pa = {1'b0, WP, 15'h0004};
        lo0 = pa[15:0] ^ {pa[23:16], 8'h00};
        apb(1'b1, OFS_WIN_PAGE, {24'h0, WP});
        for (int i = 0; i < 4; i++)
            go(OP_READ, 4'h0, pds_cls_e'(i), 16'h8004, NIL, lo0, NIL, (i == 3) ? 5 : 4);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rdat, 32'h0000002A);
        go(OP_READ, 4'h6, CLS_OTHER, 16'h8004, NIL, lo0, NIL, 5);
        go(OP_READ, 4'h4, CLS_OTHER, 16'h8004, NIL, lo0, NIL, 3);
        apb(1'b1, OFS_CORE_CTRL, 32'h0);
        go(OP_READ, 4'h0, CLS_OTHER, 16'h8004, NIL, NIL, NIL, 3);
        $display("window done");
    endtask

    task automatic t_data;
        go(OP_READ, 4'h0, CLS_MOVE, XA, NIL, XA ^ X_KEY, NIL, 3);
        go(OP_READ, 4'h8, CLS_MOVE, 16'h0801, NIL, {8'h00, 8'h08 ^ X_KEY[15:8]}, NIL, 3);
        go(OP_READ, 4'h0, CLS_MOVE, 16'h1802, NIL, 16'h1802 ^ X_KEY, NIL, 3);
        go(OP_READ, 4'h0, CLS_MOVE, 16'h2800, NIL, NIL, NIL, 3);
        go(OP_WRITE, 4'h1, CLS_MOVE, 16'h0802, NIL, NIL, NIL, 3);
        chk(wa, 16'h0810);
        chk({wb, wd}, {2'h3, W_DATA});
        go(OP_WRITE, 4'h8, CLS_MOVE, 16'h0805, NIL, NIL, NIL, 3);
        chk({wb, wd}, {2'h2, W_DATA[7:0], W_DATA[7:0]});
        $display("data done");
    endtask

    task automatic t_dual;
        go(OP_DUAL, 4'h0, CLS_MAC_PREFETCH, XA, YA, XA ^ X_KEY, YA ^ Y_KEY, 3);
        go(OP_DUAL, 4'h0, CLS_MAC_PREFETCH, YA, XA, NIL, NIL, 3);
        apb(1'b1, OFS_CORE_CTRL, 32'h4);
        apb(1'b1, OFS_MOD_START, {16'h0, YA});
        apb(1'b1, OFS_MOD_END, 32'h1806);
        go(OP_DUAL, 4'h0, CLS_MAC_PREFETCH, XA, 16'h1808, XA ^ X_KEY, YA ^ Y_KEY, 3);
        apb(1'b1, OFS_CORE_CTRL, 32'h2);
        go(OP_READ, 4'h0, CLS_MOVE, 16'h1808, NIL, YA ^ X_KEY, NIL, 3);
        $display("dual done");
    endtask

    initial
    begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        t_regs();
        t_table();
        t_window();
        t_data();
        t_dual();
        test_done();
    end

    initial
    begin
        #100000;
        bad_count++;
        test_done();
    end
endmodule // tb
